// >>> rtl/msw_pkg.sv
// Overview of operation
// - request rising edge starts readiness checks
// - request falling edge asks for real mode
// - status flag low real, high virtual
// - enter virtual only if all checks pass
// - failed check sets error flag, stores code
// - check 1: host and processor ready
// - check 2: all start-accept flags off
// - check 3: cam unchanged, mechanical program registered
// - check 4: axis numbers match program
// - check 5: all-axes servo-on command on
// - check 6: no servo start processing pending
// - check 7 encoder normal, 8 no stop
// - check 9: no axis servo error
// - check 10: no home request, output axes
// - check 11: units match on output axes
// - checks 12,13: cam data and number present
// - check 14: cam stroke within range
// - check 15: cam stroke device even
// - leave virtual on request only with axes stopped
// - automatic return on stop, ready, error
// - module fault: enter, block, flag, code
package msw_pkg;
  localparam int MSW_AXES = 32;
  localparam int MSW_AXIS_W = 5;
  // timing: operation cycle in ns, clock period in ns
  localparam int MSW_CLK_PERIOD_NS = 4;
  localparam int MSW_OP_CYCLE_NS = 888000;
  // register byte offsets
  localparam logic [7:0] MSW_REG_CTRL = 8'h00;
  localparam logic [7:0] MSW_REG_STATUS = 8'h04;
  localparam logic [7:0] MSW_REG_ERR0 = 8'h08;
  localparam logic [7:0] MSW_REG_ERR1 = 8'h0C;
  localparam logic [7:0] MSW_REG_ERR2 = 8'h10;
  localparam logic [7:0] MSW_REG_SYSCHK = 8'h14;
  localparam logic [7:0] MSW_REG_START = 8'h18;
  localparam logic [7:0] MSW_REG_SERVO_ERR = 8'h1C;
  localparam logic [7:0] MSW_REG_HOME_REQ = 8'h20;
  localparam logic [7:0] MSW_REG_AXIS_SEL = 8'h24;
  localparam logic [7:0] MSW_REG_AXIS_CFG = 8'h28;
  localparam logic [7:0] MSW_REG_AXIS_STROKE = 8'h2C;
  localparam logic [7:0] MSW_REG_MOD_ERR = 8'h30;
  localparam logic [7:0] MSW_REG_MOD_CODE = 8'h34;
  // control bits
  localparam int MSW_CTRL_REQ = 0;
  localparam int MSW_CTRL_HOST_RDY = 1;
  localparam int MSW_CTRL_SERVO_ON = 2;
  localparam int MSW_CTRL_RET_ON_ERR = 3;
  // status bits
  localparam int MSW_ST_MODE = 0;
  localparam int MSW_ST_ERR = 1;
  localparam int MSW_ST_BUSY = 2;
  // system check input bits as read back in SYSCHK
  localparam int MSW_SC_PROC_RDY = 0;
  localparam int MSW_SC_CAM_CHG = 1;
  localparam int MSW_SC_MECH_REG = 2;
  localparam int MSW_SC_AXIS_MATCH = 3;
  localparam int MSW_SC_SERVO_BUSY = 4;
  localparam int MSW_SC_ENC_OK = 5;
  localparam int MSW_SC_FSTOP = 6;
  // per-axis configuration word
  localparam int MSW_CFG_W = 8;
  localparam int MSW_CFG_TYPE_LSB = 0;
  localparam int MSW_CFG_TYPE_W = 3;
  localparam int MSW_CFG_UNITS_OK = 3;
  localparam int MSW_CFG_CAM_REG = 4;
  localparam int MSW_CFG_CAM_NO = 5;
  localparam int MSW_CFG_STROKE_ODD = 6;
  localparam int MSW_CFG_MOD_FAULT = 7;
  // axis kinds
  localparam logic [2:0] MSW_T_UNUSED = 3'h0;
  localparam logic [2:0] MSW_T_ROLLER = 3'h1;
  localparam logic [2:0] MSW_T_BALL = 3'h2;
  localparam logic [2:0] MSW_T_ROTARY = 3'h3;
  localparam logic [2:0] MSW_T_CAM = 3'h4;
  localparam logic [2:0] MSW_T_REAL = 3'h5;
  // check numbers
  localparam logic [3:0] MSW_CK_NONE = 4'h0;
  localparam logic [3:0] MSW_CK_READY = 4'h1;
  localparam logic [3:0] MSW_CK_STOPPED = 4'h2;
  localparam logic [3:0] MSW_CK_PROGRAM = 4'h3;
  localparam logic [3:0] MSW_CK_AXIS_NO = 4'h4;
  localparam logic [3:0] MSW_CK_SERVO_ON = 4'h5;
  localparam logic [3:0] MSW_CK_SERVO_BUSY = 4'h6;
  localparam logic [3:0] MSW_CK_ENCODER = 4'h7;
  localparam logic [3:0] MSW_CK_FSTOP = 4'h8;
  localparam logic [3:0] MSW_CK_SERVO_ERR = 4'h9;
  localparam logic [3:0] MSW_CK_HOME = 4'hA;
  localparam logic [3:0] MSW_CK_UNITS = 4'hB;
  localparam logic [3:0] MSW_CK_CAM_REG = 4'hC;
  localparam logic [3:0] MSW_CK_CAM_NO = 4'hD;
  localparam logic [3:0] MSW_CK_STROKE = 4'hE;
  localparam logic [3:0] MSW_CK_STROKE_ODD = 4'hF;
  localparam logic [3:0] MSW_CK_MODULE = 4'h0;
  // error info layout
  localparam logic [15:0] MSW_ERR_CODE_BASE = 16'h0100;
  localparam logic [15:0] MSW_MOD_CODE_BASE = 16'h0200;
  localparam logic [15:0] MSW_DIR_TO_VIRTUAL = 16'h0001;
  localparam logic [15:0] MSW_DIR_TO_REAL = 16'h0002;
  localparam logic [15:0] MSW_DIR_AUTO = 16'h0003;
  localparam logic [31:0] MSW_STROKE_MIN = 32'h00000001;
  localparam logic [31:0] MSW_STROKE_MAX = 32'h7FFFFFFF;
  typedef enum logic [1:0] {MSW_IDLE, MSW_GLOBAL, MSW_WALK} msw_state_e;
endpackage

// >>> rtl/msw_sync.sv
`timescale 1ns/1ps
// three-stage input synchroniser; output follows once stages two and three agree
module msw_sync #(
  parameter bit RST_VAL = 1'b0
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic async_in, // pin level from outside the clock domain
  output logic sync_out // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only when two settled stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= RST_VAL;
    end else if (s2 == s3) begin
      sync_out <= s3;
    end
  end
endmodule

// >>> rtl/msw_supervisor.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// real/virtual mode switch supervisor with APB register access
module msw_supervisor import msw_pkg::*; #(
  parameter int OP_CYCLE_CLKS = MSW_OP_CYCLE_NS / MSW_CLK_PERIOD_NS
) (
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic motion_processor_ready_complete, // processor ready
  input wire logic [31:0] axis_start_accept_flags, // per-axis busy
  input wire logic [31:0] axis_servo_error_detect, // per-axis servo error
  input wire logic [31:0] axis_home_return_request, // per-axis home request
  input wire logic cam_data_changed, // cam data altered by program
  input wire logic mech_program_registered, // mechanical program present
  input wire logic axis_numbers_match, // settings match program
  input wire logic servo_start_busy, // servo start after error reset
  input wire logic encoder_ok, // external encoder normal
  input wire logic forced_stop_in, // external forced stop pin
  output logic mode_status_flag, // high in virtual mode
  output logic mode_switch_error_flag, // sticky switch error
  output logic [31:0] output_module_error_detect // per-axis module fault
);
  localparam int OP_CNT_W = $clog2(OP_CYCLE_CLKS + 1);

  logic forced_stop;
  logic [31:0] ctrl;
  logic [MSW_AXIS_W-1:0] axis_sel;
  logic [MSW_CFG_W-1:0] cfg_mem [MSW_AXES];
  logic [31:0] stroke_mem [MSW_AXES];
  logic [15:0] err_info [3];
  logic [15:0] mod_err_code;
  logic [OP_CNT_W-1:0] op_cnt;
  logic op_tick;
  logic req_prev;
  msw_state_e state;
  logic [MSW_AXIS_W-1:0] axis_idx;
  logic [31:0] pend_mod;
  logic wr_en;
  logic rd_hit;
  logic [31:0] next_prdata;
  logic [3:0] g_fail;
  logic [3:0] a_fail;
  logic fail_now;
  logic [3:0] fail_check;
  logic [15:0] fail_dir;
  logic go_virtual;
  logic go_real;
  logic [6:0] sys_chk;

  function automatic logic is_output_axis(input logic [2:0] t);
    return (t == MSW_T_BALL) || (t == MSW_T_ROTARY) || (t == MSW_T_CAM);
  endfunction
  function automatic logic [2:0] cfg_type(input logic [MSW_CFG_W-1:0] c);
    return c[MSW_CFG_TYPE_LSB +: MSW_CFG_TYPE_W];
  endfunction
  function automatic logic stroke_ok(input logic [31:0] s);
    return (s >= MSW_STROKE_MIN) && (s <= MSW_STROKE_MAX);
  endfunction

  // forced stop arrives on a pin from outside the clock domain
  msw_sync #(
    .RST_VAL(1'b0)
  ) i_msw_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(forced_stop_in),
    .sync_out(forced_stop)
  );

  // operation cycle enable; idle-state decisions wait for this tick, the check walk then runs every clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt <= '0;
      op_tick <= 1'b0;
    end else if (op_cnt == OP_CNT_W'(OP_CYCLE_CLKS - 1)) begin
      op_cnt <= '0;
      op_tick <= 1'b1;
    end else begin
      op_cnt <= op_cnt + 1'b1;
      op_tick <= 1'b0;
    end
  end

  // apb: one wait state, write lands on the edge that sees pready high
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    next_prdata = 32'h00000000;
    case (paddr)
      MSW_REG_CTRL: next_prdata = ctrl;
      MSW_REG_STATUS: begin
        next_prdata[MSW_ST_MODE] = mode_status_flag;
        next_prdata[MSW_ST_ERR] = mode_switch_error_flag;
        next_prdata[MSW_ST_BUSY] = (state != MSW_IDLE);
      end
      MSW_REG_ERR0: next_prdata = {16'h0000, err_info[0]};
      MSW_REG_ERR1: next_prdata = {16'h0000, err_info[1]};
      MSW_REG_ERR2: next_prdata = {16'h0000, err_info[2]};
      MSW_REG_SYSCHK: next_prdata = {25'h0000000, sys_chk};
      MSW_REG_START: next_prdata = axis_start_accept_flags;
      MSW_REG_SERVO_ERR: next_prdata = axis_servo_error_detect;
      MSW_REG_HOME_REQ: next_prdata = axis_home_return_request;
      MSW_REG_AXIS_SEL: next_prdata = {27'h0000000, axis_sel};
      MSW_REG_AXIS_CFG: next_prdata = {24'h000000, cfg_mem[axis_sel]};
      MSW_REG_AXIS_STROKE: next_prdata = stroke_mem[axis_sel];
      MSW_REG_MOD_ERR: next_prdata = output_module_error_detect;
      MSW_REG_MOD_CODE: next_prdata = {16'h0000, mod_err_code};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    sys_chk[MSW_SC_PROC_RDY] = motion_processor_ready_complete;
    sys_chk[MSW_SC_CAM_CHG] = cam_data_changed;
    sys_chk[MSW_SC_MECH_REG] = mech_program_registered;
    sys_chk[MSW_SC_AXIS_MATCH] = axis_numbers_match;
    sys_chk[MSW_SC_SERVO_BUSY] = servo_start_busy;
    sys_chk[MSW_SC_ENC_OK] = encoder_ok;
    sys_chk[MSW_SC_FSTOP] = forced_stop;
  end

  // answer phase: pready pulses for one cycle per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software-written control and axis selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h00000000;
      axis_sel <= '0;
    end else if (wr_en) begin
      if (paddr == MSW_REG_CTRL) begin
        ctrl <= pwdata;
      end
      if (paddr == MSW_REG_AXIS_SEL) begin
        axis_sel <= pwdata[MSW_AXIS_W-1:0];
      end
    end
  end

  // per-axis tables; contents are meaningless until software loads them
  always_ff @(posedge pclk) begin
    if (wr_en && (paddr == MSW_REG_AXIS_CFG)) begin
      cfg_mem[axis_sel] <= pwdata[MSW_CFG_W-1:0];
    end
    if (wr_en && (paddr == MSW_REG_AXIS_STROKE)) begin
      stroke_mem[axis_sel] <= pwdata;
    end
  end

  // global checks, lowest number reported first
  always_comb begin
    g_fail = MSW_CK_NONE;
    if (!ctrl[MSW_CTRL_HOST_RDY] || !motion_processor_ready_complete) begin
      g_fail = MSW_CK_READY;
    end else if (|axis_start_accept_flags) begin
      g_fail = MSW_CK_STOPPED;
    end else if (cam_data_changed || !mech_program_registered) begin
      g_fail = MSW_CK_PROGRAM;
    end else if (!axis_numbers_match) begin
      g_fail = MSW_CK_AXIS_NO;
    end else if (!ctrl[MSW_CTRL_SERVO_ON]) begin
      g_fail = MSW_CK_SERVO_ON;
    end else if (servo_start_busy) begin
      g_fail = MSW_CK_SERVO_BUSY;
    end else if (!encoder_ok) begin
      g_fail = MSW_CK_ENCODER;
    end else if (forced_stop) begin
      g_fail = MSW_CK_FSTOP;
    end else if (|axis_servo_error_detect) begin
      g_fail = MSW_CK_SERVO_ERR;
    end
  end

  // per-axis checks on the axis being walked
  always_comb begin
    logic [2:0] t;
    logic [MSW_CFG_W-1:0] c;
    c = cfg_mem[axis_idx];
    t = cfg_type(c);
    a_fail = MSW_CK_NONE;
    if (is_output_axis(t)) begin
      if (axis_home_return_request[axis_idx]) begin
        a_fail = MSW_CK_HOME;
      end else if (!c[MSW_CFG_UNITS_OK]) begin
        a_fail = MSW_CK_UNITS;
      end else if ((t == MSW_T_CAM) && !c[MSW_CFG_CAM_REG]) begin
        a_fail = MSW_CK_CAM_REG;
      end else if ((t == MSW_T_CAM) && !c[MSW_CFG_CAM_NO]) begin
        a_fail = MSW_CK_CAM_NO;
      end else if ((t == MSW_T_CAM) && !stroke_ok(stroke_mem[axis_idx])) begin
        a_fail = MSW_CK_STROKE;
      end else if ((t == MSW_T_CAM) && c[MSW_CFG_STROKE_ODD]) begin
        a_fail = MSW_CK_STROKE_ODD;
      end
    end
  end

  // mode decisions for this cycle
  always_comb begin
    fail_now = 1'b0;
    fail_check = MSW_CK_NONE;
    fail_dir = MSW_DIR_TO_VIRTUAL;
    go_virtual = 1'b0;
    go_real = 1'b0;
    case (state)
      MSW_IDLE: begin
        if (op_tick && mode_status_flag) begin
          if (forced_stop || !ctrl[MSW_CTRL_HOST_RDY] ||
              (ctrl[MSW_CTRL_RET_ON_ERR] && (|axis_servo_error_detect))) begin
            go_real = 1'b1;
          end else if (!ctrl[MSW_CTRL_REQ] && req_prev) begin
            if (|axis_start_accept_flags) begin
              fail_now = 1'b1;
              fail_check = MSW_CK_STOPPED;
              fail_dir = MSW_DIR_TO_REAL;
            end else begin
              go_real = 1'b1;
            end
          end
        end
      end
      MSW_GLOBAL: begin
        fail_now = (g_fail != MSW_CK_NONE);
        fail_check = g_fail;
      end
      MSW_WALK: begin
        if (a_fail != MSW_CK_NONE) begin
          fail_now = 1'b1;
          fail_check = a_fail;
        end else if (axis_idx == MSW_AXIS_W'(MSW_AXES - 1)) begin
          go_virtual = 1'b1;
        end
      end
      default: fail_now = 1'b0;
    endcase
  end

  // check sequencer; request edges are sampled on the operation tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MSW_IDLE;
      axis_idx <= '0;
      req_prev <= 1'b0;
    end else begin
      if (op_tick && (state == MSW_IDLE)) begin
        req_prev <= ctrl[MSW_CTRL_REQ];
      end
      case (state)
        MSW_IDLE: begin
          if (op_tick && !mode_status_flag && ctrl[MSW_CTRL_REQ] && !req_prev) begin
            state <= MSW_GLOBAL;
          end
        end
        MSW_GLOBAL: begin
          axis_idx <= '0;
          state <= fail_now ? MSW_IDLE : MSW_WALK;
        end
        MSW_WALK: begin
          axis_idx <= axis_idx + 1'b1;
          if (fail_now || go_virtual) begin
            state <= MSW_IDLE;
          end
        end
        default: state <= MSW_IDLE;
      endcase
    end
  end

  // mode flag; a failed entry never touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_status_flag <= 1'b0;
    end else if (go_virtual) begin
      mode_status_flag <= 1'b1;
    end else if (go_real) begin
      mode_status_flag <= 1'b0;
    end
    // failure leaves the current mode in place
  end

  // sticky error flag: a new failure beats a same-cycle write-1 clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_switch_error_flag <= 1'b0;
      err_info[0] <= 16'h0000;
      err_info[1] <= 16'h0000;
      err_info[2] <= 16'h0000;
    end else if (fail_now) begin
      mode_switch_error_flag <= 1'b1;
      err_info[0] <= MSW_ERR_CODE_BASE | {12'h000, fail_check};
      err_info[1] <= {11'h000, (state == MSW_WALK) ? axis_idx : MSW_AXIS_W'(0)};
      err_info[2] <= fail_dir;
    end else if (wr_en && (paddr == MSW_REG_STATUS) && pwdata[MSW_ST_ERR]) begin
      mode_switch_error_flag <= 1'b0;
    end
  end

  // module faults are collected during the walk and applied on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_mod <= 32'h00000000;
      output_module_error_detect <= 32'h00000000;
      mod_err_code <= 16'h0000;
    end else begin
      if (state == MSW_GLOBAL) begin
        pend_mod <= 32'h00000000;
      end else if ((state == MSW_WALK) &&
                   (cfg_type(cfg_mem[axis_idx]) != MSW_T_UNUSED) &&
                   cfg_mem[axis_idx][MSW_CFG_MOD_FAULT]) begin
        pend_mod[axis_idx] <= 1'b1;
        mod_err_code <= MSW_MOD_CODE_BASE | {11'h000, axis_idx};
      end
      // enter but flag and block the faulty system
      if (go_virtual) begin
        output_module_error_detect <= pend_mod;
        if (cfg_type(cfg_mem[axis_idx]) != MSW_T_UNUSED &&
            cfg_mem[axis_idx][MSW_CFG_MOD_FAULT]) begin
          output_module_error_detect[axis_idx] <= 1'b1;
        end
      end else if (go_real) begin
        output_module_error_detect <= 32'h00000000;
      end
    end
  end
endmodule

// >>> tb/msw_supervisor_monitor.sv
`timescale 1ns/1ps
// port-level watcher: apb handshake timing and mode/error flag relations
module msw_supervisor_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready pulse
  input wire logic pslverr, // slave error
  input wire logic forced_stop_in, // stop pin
  input wire logic mode_status_flag, // virtual mode
  input wire logic mode_switch_error_flag, // switch error
  input wire logic [31:0] output_module_error_detect // module faults
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // exactly one wait state before ready
  property p_rdy_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not on second access cycle");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_err_rdy;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("slave error outside a transfer end");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  property p_entry_clean;
    $rose(mode_status_flag) |-> !$rose(mode_switch_error_flag);
  endproperty
  a_entry_clean: assert property (p_entry_clean) else $error("entered with error");
  property p_fail_real;
    $rose(mode_switch_error_flag) && !mode_status_flag |=> !mode_status_flag [*8];
  endproperty
  a_fail_real: assert property (p_fail_real) else $error("mode left real after fail");
  property p_leave_fail;
    $rose(mode_switch_error_flag) && mode_status_flag |=> mode_status_flag [*4];
  endproperty
  a_leave_fail: assert property (p_leave_fail) else $error("left virtual on error");
  property p_fstop_ret;
    mode_status_flag && $rose(forced_stop_in) |-> ##[1:24] !mode_status_flag;
  endproperty
  a_fstop_ret: assert property (p_fstop_ret) else $error("no return on forced stop");
  property p_auto_noerr;
    $fell(mode_status_flag) |-> !$rose(mode_switch_error_flag);
  endproperty
  a_auto_noerr: assert property (p_auto_noerr) else $error("error on return to real");
  property p_mod_err;
    $rose(|output_module_error_detect) |-> ##[0:2] mode_status_flag;
  endproperty
  a_mod_err: assert property (p_mod_err) else $error("module fault without entry");
endmodule

bind msw_supervisor msw_supervisor_monitor i_msw_supervisor_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .forced_stop_in, .mode_status_flag,
  .mode_switch_error_flag, .output_module_error_detect);

// >>> tb/msw_supervisor_bench.sv
`timescale 1ns/1ps
// register-level bench; op cycle shortened so each entry takes tens of cycles
module msw_supervisor_bench import msw_pkg::*;;
  localparam int OPC = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, start_in, serr_in, home_in, omed;
  logic proc_rdy, cam_chg, mech_reg, ax_match, sv_busy, enc_ok, fstop, mode, errf;
  logic [3:0] ctrl;
  logic [7:0] cfg0 [5];
  int n_errors, num_checks;

  msw_supervisor #(.OP_CYCLE_CLKS(OPC)) i_msw_supervisor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motion_processor_ready_complete(proc_rdy), .axis_start_accept_flags(start_in),
    .axis_servo_error_detect(serr_in), .axis_home_return_request(home_in),
    .cam_data_changed(cam_chg), .mech_program_registered(mech_reg),
    .axis_numbers_match(ax_match), .servo_start_busy(sv_busy), .encoder_ok(enc_ok),
    .forced_stop_in(fstop), .mode_status_flag(mode), .mode_switch_error_flag(errf),
    .output_module_error_detect(omed));

  // free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // apb transfer; request held until ready is sampled, one idle edge after
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("apb ready", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // let a tick pass, then poll busy; the check walk is at most 33 cycles
  task automatic settle();
    int k;
    k = 0;
    repeat (16) @(posedge pclk);
    do begin
      xfer(1'b0, MSW_REG_STATUS, 32'h0);
      k++;
    end while (rd[MSW_ST_BUSY] !== 1'b0 && k < 30);
    if (k >= 30) begin
      chk("busy", 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task automatic try_req(input logic r);
    ctrl[MSW_CTRL_REQ] = r;
    xfer(1'b1, MSW_REG_CTRL, {28'h0, ctrl});
    settle();
  endtask

  task automatic flags(input logic m, input logic e);
    chk("mode", 32'(m), 32'(mode));
    chk("error", 32'(e), 32'(errf));
  endtask

  task automatic ax3(input logic [7:0] c, input logic [31:0] s);
    xfer(1'b1, MSW_REG_AXIS_SEL, 32'h3);
    xfer(1'b1, MSW_REG_AXIS_CFG, {24'h0, c});
    xfer(1'b1, MSW_REG_AXIS_STROKE, s);
  endtask

  // break one readiness item; 16 is the missing mechanical program
  task automatic fault(input int n, input logic on);
    case (n)
      1: proc_rdy <= !on;
      2: start_in[5] <= on;
      3: cam_chg <= on;
      4: ax_match <= !on;
      5: ctrl[MSW_CTRL_SERVO_ON] = !on;
      6: sv_busy <= on;
      7: enc_ok <= !on;
      8: fstop <= on;
      9: serr_in[7] <= on;
      10: home_in[3] <= on;
      11: ax3(on ? 8'h34 : 8'h3C, 32'h1);
      12: ax3(on ? 8'h2C : 8'h3C, 32'h1);
      13: ax3(on ? 8'h1C : 8'h3C, 32'h1);
      14: ax3(8'h3C, on ? 32'h80000000 : 32'h1);
      15: ax3(on ? 8'h7C : 8'h3C, 32'h1);
      default: mech_reg <= !on;
    endcase
  endtask

  // main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {start_in, serr_in, home_in, cam_chg, sv_busy, fstop} = '0;
    {proc_rdy, mech_reg, ax_match, enc_ok} = 4'hF;
    ctrl = 4'h6;
    cfg0 = '{8'h00, 8'h0A, 8'h01, 8'h3C, 8'h05};
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    flags(1'b0, 1'b0);
    // axis table is not reset, so every axis is loaded
    for (int i = 0; i < 32; i++) begin
      xfer(1'b1, MSW_REG_AXIS_SEL, 32'(i));
      xfer(1'b1, MSW_REG_AXIS_CFG, {24'h0, (i < 5) ? cfg0[i] : 8'h00});
      xfer(1'b1, MSW_REG_AXIS_STROKE, 32'h1);
    end
    rdc(MSW_REG_SYSCHK, 32'h2D, "syschk");
    xfer(1'b1, MSW_REG_SYSCHK, 32'hFF);
    rdc(MSW_REG_SYSCHK, 32'h2D, "syschk ro");
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, 32'(se));
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int n = 1; n <= 16; n++) begin
      try_req(1'b0);
      fault(n, 1'b1);
      try_req(1'b1);
      flags(1'b0, 1'b1);
      rdc(MSW_REG_ERR0, {16'h0, MSW_ERR_CODE_BASE + 16'((n > 15) ? 3 : n)}, "code");
      rdc(MSW_REG_ERR1, (n >= 10 && n <= 15) ? 32'h3 : 32'h0, "axis");
      rdc(MSW_REG_ERR2, {16'h0, MSW_DIR_TO_VIRTUAL}, "dir");
      fault(n, 1'b0);
      xfer(1'b1, MSW_REG_STATUS, 32'h2);
      chk("error clear", 32'h0, 32'(errf));
    end
    $display("test readiness items done");
    // roller home request ignored, stroke at its top, module fault does not block
    ax3(8'h3C, 32'h7FFFFFFF);
    xfer(1'b1, MSW_REG_AXIS_SEL, 32'h1);
    xfer(1'b1, MSW_REG_AXIS_CFG, 32'h8A);
    home_in[2] <= 1'b1;
    try_req(1'b0);
    try_req(1'b1);
    flags(1'b1, 1'b0);
    rdc(MSW_REG_HOME_REQ, 32'h4, "home mirror");
    rdc(MSW_REG_MOD_ERR, 32'h2, "module reg");
    rdc(MSW_REG_STATUS, 32'h1, "status");
    chk("module fault", 32'h2, omed);
    rdc(MSW_REG_MOD_CODE, {16'h0, MSW_MOD_CODE_BASE + 16'h1}, "module code");
    home_in[2] <= 1'b0;
    $display("test entry done");
    // leave while an axis still moves
    start_in[0] <= 1'b1;
    try_req(1'b0);
    flags(1'b1, 1'b1);
    rdc(MSW_REG_ERR2, {16'h0, MSW_DIR_TO_REAL}, "leave dir");
    rdc(MSW_REG_START, 32'h1, "start mirror");
    start_in[0] <= 1'b0;
    xfer(1'b1, MSW_REG_STATUS, 32'h2);
    fstop <= 1'b1;
    settle();
    flags(1'b0, 1'b0);
    chk("module clear", 32'h0, omed);
    fstop <= 1'b0;
    $display("test leave done");
    // clean leave, then returns on ready drop and on servo error
    try_req(1'b1);
    flags(1'b1, 1'b0);
    try_req(1'b0);
    flags(1'b0, 1'b0);
    try_req(1'b1);
    ctrl[MSW_CTRL_HOST_RDY] = 1'b0;
    try_req(1'b1);
    flags(1'b0, 1'b0);
    ctrl[MSW_CTRL_HOST_RDY] = 1'b1;
    try_req(1'b0);
    try_req(1'b1);
    flags(1'b1, 1'b0);
    ctrl[MSW_CTRL_RET_ON_ERR] = 1'b1;
    serr_in[4] <= 1'b1;
    try_req(1'b1);
    flags(1'b0, 1'b0);
    rdc(MSW_REG_SERVO_ERR, 32'h10, "servo err mirror");
    $display("test auto return done");
    print_verdict();
  end
endmodule
